// File: logic/iir_map.svh
// Purpose: constants for the measurement filter block
// Assumes: 14-bit results, 16 channels
// Notes: definitions only
`ifndef IIR_MAP_SVH
`define IIR_MAP_SVH
`define IIR_DW        14
`define IIR_FRAC      3
`define IIR_AW        17
`define IIR_NCH       16
`define IIR_CHW       4
`define IIR_CW        3
`define IIR_FC_RESET  3'h2
`define IIR_FC_OFF    3'h7
`define IIR_FC_MIN    3'h0
`define IIR_FIFO_D    32
`define IIR_SUMW      18
`endif

// File: logic/iir_pkg.sv
// Purpose: types for the measurement filter block
// Assumes: nothing
// Notes: states in gray order
package iir_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_SUM  = 2'h3
  } state_t;
endpackage : iir_pkg

// File: logic/measurement_iir_data_control.sv
// Purpose: per-channel first-order recursive filter with result routing and stack total
// Assumes: samples arrive one channel per beat; inputs synchronous to i_clk
// Notes: accumulator holds extra fractional bits
//
// Contract
// (RULE1) raw converter data goes straight on, or through correction when calibration enabled
// (RULE2) every enabled channel has its own accumulator
// (RULE3) total is sum of chosen per-channel set, not filtered itself
// (RULE4) output is fc times sample plus one-minus-fc times old output
// (RULE5) coefficient code is three bits, resets to 010, weight three eighths
// (RULE6) weight equals code plus one, over eight
// (RULE7) code 111 makes output equal the newest sample
// (RULE8) balancing cycles always filter; code 111 becomes 000 there
// (RULE9) init option loads next sample straight into accumulator
// (RULE10) 12-bit step settling follows weight (33 down to 1 samples)
// (RULE11) 14-bit step settling follows weight (44 down to 1 samples)
// (RULE12) update bit clear leaves accumulator unchanged
// (RULE13) update bit set folds the scaled sample into accumulator
// (RULE14) read-select picks filtered or raw values for results
// (RULE15) single buffer: load filter at end of requested sequence
// (RULE16) double buffer: load previous results at start of next sequence
// (RULE17) no scan: load during data move if ready flag is zero
// (RULE18) host keeps diagnostic acquisitions out of the filter
// (RULE19) host should amend every ordinary acquisition
// (RULE20) update/read pairs: off, stale read, update raw, update filtered
// (RULE21) init bit zero keeps accumulators and amends normally; a channel's first load after reset still seeds directly
// (RULE22) out-of-scan move copies raw or filtered per read-select
// (RULE23) accumulator keeps fractional bits beyond result width
`timescale 1ns/10ps
`include "iir_map.svh"

module iir_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             empty;
  logic             push;
  assign empty       = (wr_ptr == rd_ptr);
  assign push        = i_valid && o_ready;
  assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
  assign next_rd_ptr = (i_ready && !empty) ? rd_ptr + 1'b1 : rd_ptr;
  assign o_valid     = !empty;
  assign o_data      = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_ready <= 1'b1;
    end
    else
    begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      o_ready <= !((next_wr_ptr[AW] != next_rd_ptr[AW]) && (next_wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]));
    end
  end
endmodule : iir_fifo

module measurement_iir_data_control (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_sample_valid,
  output logic                        o_sample_ready,
  input  wire logic [`IIR_DW-1:0]     i_sample_raw,
  input  wire logic [`IIR_CHW-1:0]    i_sample_chan,
  input  wire logic [`IIR_DW-1:0]     i_sample_cal,
  input  wire logic                   i_calibration_enable,
  input  wire logic [`IIR_NCH-1:0]    i_channel_enable,
  input  wire logic                   i_filter_update_enable,
  input  wire logic                   i_read_filtered_select,
  input  wire logic [`IIR_CW-1:0]     i_filter_coeff_code,
  input  wire logic                   i_scan_filter_init,
  input  wire logic                   i_balance_filter_init,
  input  wire logic                   i_balance_active,
  input  wire logic                   i_double_buffer_enable,
  input  wire logic                   i_scan_request,
  input  wire logic                   i_scan_start,
  input  wire logic                   i_scan_end,
  input  wire logic                   i_data_move,
  input  wire logic                   i_transfer_ready_flag,
  input  wire logic                   i_result_read,
  input  wire logic [`IIR_CHW-1:0]    i_result_chan,
  output logic [`IIR_DW-1:0]          o_result,
  output logic [`IIR_SUMW-1:0]        o_cell_sum,
  output logic                        o_results_loaded,
  output logic [`IIR_CW-1:0]          o_coeff_effective
);
  logic [`IIR_AW-1:0]  acc [`IIR_NCH];
  logic [`IIR_DW-1:0]  alu [`IIR_NCH];
  logic [`IIR_DW-1:0]  res [`IIR_NCH];
  logic [`IIR_NCH-1:0] seeded;
  logic [`IIR_NCH-1:0] init_pend;
  logic [`IIR_CW-1:0]  coeff;
  logic [`IIR_CW-1:0]  coeff_reg;
  logic                f_valid;
  logic                f_ready;
  logic [`IIR_DW+`IIR_CHW-1:0] f_data;
  logic [`IIR_DW+`IIR_CHW-1:0] in_word;
  logic                amend_go;
  logic                amend_pend;
  logic                copy_go;
  logic [`IIR_CHW-1:0] ch_idx;
  logic [`IIR_SUMW-1:0] sum_acc;
  logic [`IIR_AW-1:0]  acc_new;
  logic [`IIR_DW-1:0]  chosen;
  iir_pkg::state_t     state;

  // newest sample weighted (c+1)/8, history (7-c)/8, all in fractional units
  function automatic logic [`IIR_AW-1:0] iir_step(input logic [`IIR_AW-1:0] y,
                                                 input logic [`IIR_DW-1:0] x,
                                                 input logic [`IIR_CW-1:0] c);
    logic [`IIR_AW+3:0] t;
    t = ({4'h0, x, 3'h0} * ({3'h0, c} + 4'h1)) + ({4'h0, y} * (4'h7 - {1'b0, c}));
    return t[`IIR_AW+2:3]; // RULE4 RULE6 RULE23
  endfunction : iir_step

  function automatic logic [`IIR_DW-1:0] acc_out(input logic [`IIR_AW-1:0] a);
    return a[`IIR_AW-1:`IIR_FRAC];
  endfunction : acc_out

  // code 111 is forced to 000 under automatic balancing
  assign coeff = (i_balance_active && i_filter_coeff_code == `IIR_FC_OFF) ? `IIR_FC_MIN : i_filter_coeff_code; // RULE8
  assign in_word = {i_sample_chan, i_calibration_enable ? i_sample_cal : i_sample_raw}; // RULE1

  iir_fifo #(
    .WIDTH (`IIR_DW+`IIR_CHW),
    .DEPTH (`IIR_FIFO_D)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (i_sample_valid),
    .o_ready (o_sample_ready),
    .i_data  (in_word),
    .o_valid (f_valid),
    .i_ready (f_ready),
    .o_data  (f_data)
  );
  // stall the drain while a filter load or result copy walks the channels
  assign f_ready = (state == iir_pkg::ST_IDLE) && !amend_pend;

  // acquisitions land in the alu set; disabled channels are dropped
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < `IIR_NCH; i++)
      begin
        alu[i] <= '0;
      end
    end
    else if (f_valid && f_ready && i_channel_enable[f_data[`IIR_DW+`IIR_CHW-1:`IIR_DW]]) // RULE2
    begin
      alu[f_data[`IIR_DW+`IIR_CHW-1:`IIR_DW]] <= f_data[`IIR_DW-1:0];
    end
  end

  // load timing: end of sequence, start of next, or an out-of-scan move
  assign amend_go = i_filter_update_enable && (
                    (!i_double_buffer_enable && i_scan_request && i_scan_end) || // RULE15 RULE13
                    (i_double_buffer_enable && i_scan_request && i_scan_start) || // RULE16
                    (!i_scan_request && i_data_move && !i_transfer_ready_flag)); // RULE17
  assign copy_go = (i_scan_request && (i_double_buffer_enable ? i_scan_start : i_scan_end)) ||
                   (!i_scan_request && i_data_move && !i_transfer_ready_flag); // RULE22

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      amend_pend <= 1'b0;
    end
    else if (copy_go && state == iir_pkg::ST_IDLE)
    begin
      amend_pend <= amend_go;
    end
    else if (state != iir_pkg::ST_RUN)
    begin
      amend_pend <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state  <= iir_pkg::ST_IDLE;
      ch_idx <= '0;
    end
    else
    begin
      case (state)
        iir_pkg::ST_IDLE:
        begin
          ch_idx <= '0;
          if (copy_go)
          begin
            state <= iir_pkg::ST_RUN;
          end
        end
        iir_pkg::ST_RUN:
        begin
          ch_idx <= ch_idx + 1'b1;
          if (ch_idx == `IIR_CHW'(`IIR_NCH-1))
          begin
            state <= iir_pkg::ST_SUM;
          end
        end
        iir_pkg::ST_SUM:
        begin
          state <= iir_pkg::ST_IDLE;
        end
        default:
        begin
          state <= iir_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // init request arms every channel; the next load pass seeds enabled channels directly and disarms disabled ones too
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      init_pend <= '0;
    end
    else if (i_scan_filter_init || i_balance_filter_init)
    begin
      init_pend <= '1; // RULE9
    end
    else if (state == iir_pkg::ST_RUN && amend_pend)
    begin
      init_pend[ch_idx] <= 1'b0; // RULE21
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      coeff_reg <= `IIR_FC_RESET; // RULE5
    end
    else if (state == iir_pkg::ST_IDLE)
    begin
      coeff_reg <= coeff;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      seeded <= '0;
      for (int i = 0; i < `IIR_NCH; i++)
      begin
        acc[i] <= '0;
      end
    end
    else if (state == iir_pkg::ST_RUN && amend_pend && i_channel_enable[ch_idx]) // RULE2 RULE12 RULE20
    begin
      seeded[ch_idx] <= 1'b1;
      acc[ch_idx]    <= acc_new; // RULE4 RULE7 RULE10 RULE11 RULE13
    end
  end

  // filtered copy takes the value loaded in this same cycle, so a read never lags the update
  assign acc_new = (init_pend[ch_idx] || !seeded[ch_idx]) ? {alu[ch_idx], `IIR_FRAC'(0)} // RULE9
                 : iir_step(acc[ch_idx], alu[ch_idx], coeff_reg); // RULE4
  assign chosen  = i_read_filtered_select ? acc_out(amend_pend ? acc_new : acc[ch_idx]) : alu[ch_idx]; // RULE14 RULE20
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sum_acc <= '0;
      for (int i = 0; i < `IIR_NCH; i++)
      begin
        res[i] <= '0;
      end
    end
    else if (state == iir_pkg::ST_IDLE)
    begin
      sum_acc <= '0;
    end
    else if (state == iir_pkg::ST_RUN && i_channel_enable[ch_idx])
    begin
      res[ch_idx] <= chosen; // RULE14 RULE20 RULE22
      sum_acc     <= sum_acc + `IIR_SUMW'(chosen); // RULE3
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cell_sum        <= '0;
      o_results_loaded  <= 1'b0;
      o_result          <= '0;
      o_coeff_effective <= `IIR_FC_RESET;
    end
    else
    begin
      o_results_loaded  <= (state == iir_pkg::ST_SUM);
      o_coeff_effective <= coeff;
      if (state == iir_pkg::ST_SUM)
      begin
        o_cell_sum <= sum_acc; // RULE3
      end
      if (i_result_read)
      begin
        o_result <= res[i_result_chan];
      end
    end
  end

  AST_BAL_FORCE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
    (i_balance_active && i_filter_coeff_code == `IIR_FC_OFF) |=> o_coeff_effective == `IIR_FC_MIN)
    else $error("balance coefficient not forced");
  AST_RESET_FC: assert property (@(posedge i_clk) $fell(i_rst) |-> coeff_reg == `IIR_FC_RESET) // RULE5
    else $error("coefficient reset value wrong");
  sequence s_copy;
    state == iir_pkg::ST_IDLE && copy_go ##1 state == iir_pkg::ST_RUN;
  endsequence
  AST_COPY_DONE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE22
    s_copy |-> ##16 state == iir_pkg::ST_SUM ##1 o_results_loaded)
    else $error("result copy did not finish");
  AST_HOLD_ACC: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
    (state == iir_pkg::ST_RUN && !amend_pend) |=> acc[$past(ch_idx)] == $past(acc[ch_idx]))
    else $error("accumulator changed without update");
  AST_NO_AMEND_OFF: assert property (@(posedge i_clk) disable iff (i_rst) // RULE20
    (state == iir_pkg::ST_IDLE && copy_go && !i_filter_update_enable) |=> !amend_pend)
    else $error("load armed with update off");
  AST_AMEND_SB: assert property (@(posedge i_clk) disable iff (i_rst) // RULE15
    (state == iir_pkg::ST_IDLE && i_filter_update_enable && !i_double_buffer_enable && i_scan_request && i_scan_end)
    |=> amend_pend)
    else $error("single buffer load missed");
  AST_AMEND_DB: assert property (@(posedge i_clk) disable iff (i_rst) // RULE16
    (state == iir_pkg::ST_IDLE && i_filter_update_enable && i_double_buffer_enable && i_scan_request && i_scan_start)
    |=> amend_pend)
    else $error("double buffer load missed");
  AST_MOVE_READY: assert property (@(posedge i_clk) disable iff (i_rst) // RULE17
    (state == iir_pkg::ST_IDLE && !i_scan_request && i_data_move && i_transfer_ready_flag) |=> state == iir_pkg::ST_IDLE)
    else $error("move taken while ready flag set");
  AST_UNITY: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
    (state == iir_pkg::ST_RUN && amend_pend && i_channel_enable[ch_idx] && coeff_reg == `IIR_FC_OFF)
    |=> acc_out(acc[$past(ch_idx)]) == $past(alu[ch_idx]))
    else $error("unity coefficient not passing sample");
endmodule : measurement_iir_data_control

// File: tb/alu_sample_source.sv
// Purpose: stand-in for the sequencer ALU offering one sample per handshake
// Assumes: sample taken on a rising edge with valid and ready high
// Notes: idle data lines carry the inverse of the last value
`timescale 1ns/10ps
`include "iir_map.svh"

module alu_sample_source (
  input  wire logic               i_clk,
  input  wire logic               i_ready,
  output logic                    o_valid,
  output logic [`IIR_DW-1:0]      o_raw,
  output logic [`IIR_DW-1:0]      o_cal,
  output logic [`IIR_CHW-1:0]     o_chan
);
  initial
  begin
    o_valid = 1'b0;
    o_raw = 14'h0000;
    o_cal = 14'h3fff;
    o_chan = 4'h0;
  end

  // only ordinary acquisitions are offered, never diagnostic ones
  task send(input logic [3:0] ch, input logic [13:0] raw, input logic [13:0] cal, input int gap);
    repeat (gap + 1) @(negedge i_clk);
    o_valid = 1'b1;
    o_raw = raw;
    o_cal = cal;
    o_chan = ch;
    while (i_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    o_valid = 1'b0;
    // stale values must never look valid
    o_raw = ~raw;
    o_cal = ~cal;
    o_chan = ~ch;
  endtask : send
endmodule : alu_sample_source

// File: tb/measurement_iir_data_control_bench.sv
// Purpose: self-checking bench for the measurement filter block
// Assumes: samples multiples of 100 keep eighth-step arithmetic exact
// Notes: a filtered read taken with an update shows the value loaded in that same copy
`timescale 1ns/10ps
`include "iir_map.svh"

module measurement_iir_data_control_bench;
  logic                 i_clk = 1'b0;
  logic                 i_rst = 1'b1;
  logic                 valid;
  logic                 ready;
  logic [`IIR_DW-1:0]   raw;
  logic [`IIR_DW-1:0]   cal;
  logic [`IIR_CHW-1:0]  chan;
  logic                 cal_en = 1'b0;
  logic [`IIR_NCH-1:0]  ch_en = 16'h0003;
  logic                 upd = 1'b0;
  logic                 rdf = 1'b0;
  logic [`IIR_CW-1:0]   code = 3'h2;
  logic                 sinit = 1'b0;
  logic                 binit = 1'b0;
  logic                 bal = 1'b0;
  logic                 dbl = 1'b0;
  logic                 scan_req = 1'b0;
  logic                 scan_start = 1'b0;
  logic                 scan_end = 1'b0;
  logic                 move = 1'b0;
  logic                 rdy_flag = 1'b0;
  logic                 rd = 1'b0;
  logic [`IIR_CHW-1:0]  rd_ch = 4'h0;
  logic [`IIR_DW-1:0]   result;
  logic [`IIR_SUMW-1:0] cell_sum;
  logic                 loaded;
  logic [`IIR_CW-1:0]   coeff_eff;
  int                   miscompares = 0;
  int                   checks = 0;

  always #2.5 i_clk = ~i_clk;

  alu_sample_source u_src (.i_clk(i_clk), .i_ready(ready), .o_valid(valid), .o_raw(raw), .o_cal(cal),
    .o_chan(chan));

  measurement_iir_data_control u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sample_valid(valid),
    .o_sample_ready(ready), .i_sample_raw(raw), .i_sample_chan(chan), .i_sample_cal(cal),
    .i_calibration_enable(cal_en), .i_channel_enable(ch_en), .i_filter_update_enable(upd),
    .i_read_filtered_select(rdf), .i_filter_coeff_code(code), .i_scan_filter_init(sinit),
    .i_balance_filter_init(binit), .i_balance_active(bal), .i_double_buffer_enable(dbl),
    .i_scan_request(scan_req), .i_scan_start(scan_start), .i_scan_end(scan_end), .i_data_move(move),
    .i_transfer_ready_flag(rdy_flag), .i_result_read(rd), .i_result_chan(rd_ch), .o_result(result),
    .o_cell_sum(cell_sum), .o_results_loaded(loaded), .o_coeff_effective(coeff_eff));

  task check_val(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task check_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag

  task stop_test;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // copy answer comes 18 cycles after the trigger; 25 leaves margin
  task wait_loaded(input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (25)
    begin
      @(negedge i_clk);
      if (loaded === 1'b1)
        hit = 1'b1;
    end
    check_flag(hit, exp);
  endtask : wait_loaded

  task pulse(input int k, input logic exp);
    @(negedge i_clk);
    case (k)
      0: move = 1'b1;
      1: scan_start = 1'b1;
      default: scan_end = 1'b1;
    endcase
    @(negedge i_clk);
    move = 1'b0;
    scan_start = 1'b0;
    scan_end = 1'b0;
    wait_loaded(exp);
  endtask : pulse

  task do_move(input logic u, input logic r);
    @(negedge i_clk);
    upd = u;
    rdf = r;
    pulse(0, 1'b1);
  endtask : do_move

  task read_chk(input logic [3:0] ch, input logic [13:0] exp);
    @(negedge i_clk);
    rd = 1'b1;
    rd_ch = ch;
    @(negedge i_clk);
    rd = 1'b0;
    check_val({4'h0, result}, {4'h0, exp});
  endtask : read_chk

  task t_reset;
    check_flag(loaded, 1'b0);
    check_flag(ready, 1'b1);
    check_val({15'h0, coeff_eff}, 18'h2);
    check_val(cell_sum, 18'h0);
  endtask : t_reset

  // channel 2 is disabled and must stay out of the total
  task t_route;
    for (int i = 0; i < 2; i++)
    begin
      cal_en = i[0];
      u_src.send(4'h0, 14'd100, 14'd200, 0);
      u_src.send(4'h1, 14'd300, 14'd400, 3 * i);
      u_src.send(4'h2, 14'd500, 14'd600, 0);
      repeat (6) @(negedge i_clk);
      do_move(1'b0, 1'b0);
      read_chk(4'h0, i ? 14'd200 : 14'd100);
      check_val(cell_sum, i ? 18'd600 : 18'd400);
    end
    cal_en = 1'b0;
  endtask : t_route

  // seed with 800, fold in 1600, then read the accumulator without updating
  task t_filter(input logic b, input logic [2:0] c, input logic [13:0] exp);
    @(negedge i_clk);
    bal = b;
    code = c;
    sinit = ~b;
    binit = b;
    @(negedge i_clk);
    sinit = 1'b0;
    binit = 1'b0;
    u_src.send(4'h0, 14'd800, 14'd800, 0);
    repeat (6) @(negedge i_clk);
    do_move(1'b1, 1'b0);
    u_src.send(4'h0, 14'd1600, 14'd1600, 0);
    repeat (6) @(negedge i_clk);
    do_move(1'b1, 1'b0);
    read_chk(4'h0, 14'd1600);
    do_move(1'b0, 1'b1);
    read_chk(4'h0, exp);
    check_val(cell_sum, {4'h0, exp} + 18'd400);
    do_move(1'b0, 1'b1);
    read_chk(4'h0, exp);
  endtask : t_filter

  // no init: previous accumulator 900 blends with 400 at weight one half
  task t_continue;
    code = 3'h3;
    u_src.send(4'h0, 14'd400, 14'd400, 0);
    repeat (6) @(negedge i_clk);
    do_move(1'b1, 1'b1);
    read_chk(4'h0, 14'd650);
    do_move(1'b0, 1'b1);
    read_chk(4'h0, 14'd650);
  endtask : t_continue

  // unity coefficient during the scan loads leaves channel 0 at 400
  task t_scan;
    upd = 1'b1;
    code = 3'h7;
    scan_req = 1'b1;
    pulse(1, 1'b0);
    pulse(2, 1'b1);
    dbl = 1'b1;
    pulse(2, 1'b0);
    pulse(1, 1'b1);
    pulse(0, 1'b0);
    scan_req = 1'b0;
    upd = 1'b0;
    rdy_flag = 1'b1;
    pulse(0, 1'b0);
    rdy_flag = 1'b0;
    u_src.send(4'h0, 14'd1200, 14'd1200, 0);
    repeat (6) @(negedge i_clk);
    rdf = 1'b0;
    pulse(0, 1'b1);
    read_chk(4'h0, 14'd1200);
    rdf = 1'b1;
    pulse(0, 1'b1);
    read_chk(4'h0, 14'd400);
  endtask : t_scan

  initial
  begin
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    t_reset();
    t_route();
    for (int c = 0; c < 8; c++)
      t_filter(1'b0, c[2:0], 14'(800 + 100 * (c + 1)));
    t_filter(1'b1, 3'h7, 14'd900);
    check_val({15'h0, coeff_eff}, 18'h0);
    bal = 1'b0;
    t_continue();
    t_scan();
    stop_test();
  end

  // the sequence needs about 1600 cycles; 20000 allows for slow answers
  initial
  begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule : measurement_iir_data_control_bench
